// File: ccrb_pkg.sv
// Package for the codec control register bank: register indices, field positions,
// reset values and the decoded control struct.
// Assumes a single 25 MHz clock domain; no other file is needed.
package ccrb_pkg;

    // ------------------------------------------------------------
    // Register indices (3-bit register address field)
    // ------------------------------------------------------------
    localparam logic [2:0] REG_MODE   = 3'h0;
    localparam logic [2:0] REG_CLOCK  = 3'h1;
    localparam logic [2:0] REG_POWER  = 3'h2;
    localparam logic [2:0] REG_GAIN   = 3'h3;
    localparam logic [2:0] REG_TIMING = 3'h4;
    localparam logic [2:0] REG_ATAP   = 3'h5;
    localparam logic [2:0] REG_DTAPLO = 3'h6;
    localparam int         REG_COUNT  = 7;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET_VAL    = 8'h00;
    localparam logic [2:0] RESET_MCLK_TICKS = 3'h4;
    localparam logic [2:0] RESET_CNT_ZERO   = 3'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_OPMODE_BIT  = 0;
    localparam int MODE_MIXED_BIT   = 1;
    localparam int MODE_DLOOP_BIT   = 2;
    localparam int MODE_SLOOP_BIT   = 3;
    localparam int MODE_CASC_LSB    = 4;
    localparam int MODE_SWRST_BIT   = 7;
    localparam int CLK_RATE_LSB     = 0;
    localparam int CLK_SCLK_LSB     = 2;
    localparam int CLK_MCLK_LSB     = 4;
    localparam int CLK_ECHO_BIT     = 7;
    localparam int PWR_GLOBAL_BIT   = 0;
    localparam int PWR_ATAP_BIT     = 1;
    localparam int PWR_INAMP_BIT    = 2;
    localparam int PWR_ADC_BIT      = 3;
    localparam int PWR_DAC_BIT      = 4;
    localparam int PWR_REF_BIT      = 5;
    localparam int PWR_REFPIN_BIT   = 6;
    localparam int PWR_RSVD_BIT     = 7;
    localparam int GAIN_IN_LSB      = 0;
    localparam int GAIN_MODRST_BIT  = 3;
    localparam int GAIN_OUT_LSB     = 4;
    localparam int GAIN_MUTE_BIT    = 7;
    localparam int TIM_LEAD_LSB     = 0;
    localparam int TIM_ISKIP_BIT    = 5;
    localparam int TIM_DTAP_BIT     = 6;
    localparam int TIM_TEST_BIT     = 7;
    localparam int ATAP_COEFF_LSB   = 0;
    localparam int ATAP_SEEN_BIT    = 5;
    localparam int ATAP_INV_BIT     = 6;
    localparam int ATAP_LOOP_BIT    = 7;

    // ------------------------------------------------------------
    // Divider encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SCLK_DIV8  = 2'h0;
    localparam logic [1:0] SCLK_DIV4  = 2'h1;
    localparam logic [1:0] SCLK_DIV2  = 2'h2;
    localparam logic [1:0] SCLK_DIV1  = 2'h3;
    localparam logic [1:0] RATE_DIV2048 = 2'h0;
    localparam logic [1:0] RATE_DIV1024 = 2'h1;
    localparam logic [1:0] RATE_DIV512  = 2'h2;
    localparam logic [1:0] RATE_DIV256  = 2'h3;
    localparam logic [11:0] DIV_2048 = 12'h7FF;
    localparam logic [11:0] DIV_1024 = 12'h3FF;
    localparam logic [11:0] DIV_512  = 12'h1FF;
    localparam logic [11:0] DIV_256  = 12'h0FF;
    localparam logic [3:0]  DIV_8    = 4'h7;
    localparam logic [3:0]  DIV_4    = 4'h3;
    localparam logic [3:0]  DIV_2    = 4'h1;
    localparam logic [3:0]  DIV_1    = 4'h0;

    // Reset sequencer states
    typedef enum logic [2:0] {
        CCRB_RUN   = 3'b001,
        CCRB_START = 3'b010,
        CCRB_HOLD  = 3'b100
    } ccrb_state_type;

    // Decoded control bundle
    typedef struct packed {
        logic       operating_mode_select;
        logic       mixed_operation_enable;
        logic       digital_loopback_enable;
        logic       serial_port_loopback_enable;
        logic [2:0] cascade_count;
        logic [1:0] sample_rate_sel;
        logic [1:0] serial_clock_sel;
        logic [2:0] master_clock_sel;
        logic       control_word_echo_enable;
        logic       global_power_on;
        logic       analog_tap_power_on;
        logic       inbound_amplifier_power_on;
        logic       adc_power_on;
        logic       dac_power_on;
        logic       reference_power_on;
        logic       reference_pin_drive;
        logic [2:0] inbound_gain_sel;
        logic       modulator_reset_hold;
        logic [2:0] outbound_gain_sel;
        logic       converter_mute;
        logic [4:0] converter_lead;
        logic       interpolator_skip;
        logic       digital_tap_enable;
        logic       test_operation_enable;
        logic [4:0] analog_tap_coeff;
        logic       single_ended_or_tap_enable;
        logic       polarity_flip_enable;
        logic       analog_loop_or_tap_silence;
        logic [7:0] digital_tap_coeff_low;
    } ccrb_ctrl_type;

endpackage

// File: ccrb_bank.sv
// Control register bank of one codec channel: seven 8-bit registers, a reset
// sequencer and the sample and serial clock enable dividers they steer.
// Assumes the control-word parser hands over a one-cycle write or read strobe
// with register index and data, synchronous to clk_i; reset pin is external.
`timescale 1ns/100ps
module ccrb_bank (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   arst_n_i,
    // Converter master clock enable (one-cycle pulse per tick)
    input  wire logic                   mclk_en_i,
    // Reset pin of the channel, asynchronous to clk_i
    input  wire logic                   reset_pin_n_i,
    // Register access from the control-word parser
    input  wire logic                   wr_en_i,
    input  wire logic                   rd_en_i,
    input  wire logic [2:0]             reg_addr_i,
    input  wire logic [7:0]             wr_data_i,
    output logic      [7:0]             rd_data_o,
    output logic                        rd_valid_o,
    // Decoded controls
    output ccrb_pkg::ccrb_ctrl_type     ctrl_o,
    output logic                        reference_output_pin_o,
    output logic                        reset_busy_o,
    output logic                        sclk_en_o,
    output logic                        sample_en_o
);

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    logic [7:0]               regs_q [ccrb_pkg::REG_COUNT];
    ccrb_pkg::ccrb_state_type state_q;
    logic [2:0]               rst_cnt_q;
    logic                     pin_meta_q;
    logic                     pin_sync_q;
    logic                     swrst_req;
    logic                     in_reset;
    logic [3:0]               sclk_cnt_q;
    logic [11:0]              rate_cnt_q;
    logic                     rd_legal;

    // Index check shared by read and write paths
    function automatic logic ccrb_legal(input logic [2:0] a);
        return a <= ccrb_pkg::REG_DTAPLO;
    endfunction

    // Divider reloads from the selector codes
    function automatic logic [3:0] ccrb_sclk_div(input logic [1:0] sel);
        if (sel == ccrb_pkg::SCLK_DIV8) begin
            return ccrb_pkg::DIV_8;
        end else if (sel == ccrb_pkg::SCLK_DIV4) begin
            return ccrb_pkg::DIV_4;
        end else if (sel == ccrb_pkg::SCLK_DIV2) begin
            return ccrb_pkg::DIV_2;
        end
        return ccrb_pkg::DIV_1;
    endfunction

    function automatic logic [11:0] ccrb_rate_div(input logic [1:0] sel);
        if (sel == ccrb_pkg::RATE_DIV2048) begin
            return ccrb_pkg::DIV_2048;
        end else if (sel == ccrb_pkg::RATE_DIV1024) begin
            return ccrb_pkg::DIV_1024;
        end else if (sel == ccrb_pkg::RATE_DIV512) begin
            return ccrb_pkg::DIV_512;
        end
        return ccrb_pkg::DIV_256;
    endfunction

    // ------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------
    // Two flops; only the second one is looked at
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= reset_pin_n_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Software reset is the write of a 1 into the mode register top bit
    assign swrst_req = wr_en_i && (reg_addr_i == ccrb_pkg::REG_MODE)
                       && wr_data_i[ccrb_pkg::MODE_SWRST_BIT];
    assign in_reset  = (state_q != ccrb_pkg::CCRB_RUN);

    // ------------------------------------------------------------
    // Reset sequencer: four master clock ticks per reset
    // ------------------------------------------------------------
    // A pin held low keeps restarting the count, so the four ticks run from release
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q   <= ccrb_pkg::CCRB_START;
            rst_cnt_q <= ccrb_pkg::RESET_CNT_ZERO;
        end else if (!pin_sync_q || swrst_req) begin
            state_q   <= ccrb_pkg::CCRB_START;
            rst_cnt_q <= ccrb_pkg::RESET_CNT_ZERO;
        end else begin
            case (state_q)
                ccrb_pkg::CCRB_START: begin
                    state_q <= ccrb_pkg::CCRB_HOLD;
                end
                ccrb_pkg::CCRB_HOLD: begin
                    if (mclk_en_i) begin
                        if (rst_cnt_q == ccrb_pkg::RESET_MCLK_TICKS - 3'h1) begin
                            state_q <= ccrb_pkg::CCRB_RUN;
                        end
                        rst_cnt_q <= rst_cnt_q + 3'h1;
                    end
                end
                default: begin
                    state_q <= ccrb_pkg::CCRB_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Writes during a reset are dropped; the bank stays at zero until it ends
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < ccrb_pkg::REG_COUNT; i++) begin
                regs_q[i] <= ccrb_pkg::REG_RESET_VAL;
            end
        end else if (in_reset || swrst_req || !pin_sync_q) begin
            for (int i = 0; i < ccrb_pkg::REG_COUNT; i++) begin
                regs_q[i] <= ccrb_pkg::REG_RESET_VAL;
            end
        end else if (wr_en_i && ccrb_legal(reg_addr_i)) begin
            // Reserved power bit stored as written; controller keeps it 0
            regs_q[reg_addr_i] <= wr_data_i;
        end
    end

    // Read-back; unmapped index answers zero
    assign rd_legal = ccrb_legal(reg_addr_i);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                rd_data_o <= rd_legal ? regs_q[reg_addr_i] : 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Field decode into registered controls
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_o                 <= '0;
            reference_output_pin_o <= 1'b0;
            reset_busy_o           <= 1'b1;
        end else begin
            reset_busy_o <= in_reset;
            ctrl_o.operating_mode_select       <= regs_q[0][ccrb_pkg::MODE_OPMODE_BIT];
            ctrl_o.mixed_operation_enable      <= regs_q[0][ccrb_pkg::MODE_MIXED_BIT];
            ctrl_o.digital_loopback_enable     <= regs_q[0][ccrb_pkg::MODE_DLOOP_BIT];
            ctrl_o.serial_port_loopback_enable <= regs_q[0][ccrb_pkg::MODE_SLOOP_BIT];
            ctrl_o.cascade_count    <= regs_q[0][ccrb_pkg::MODE_CASC_LSB +: 3];
            ctrl_o.sample_rate_sel  <= regs_q[1][ccrb_pkg::CLK_RATE_LSB +: 2];
            ctrl_o.serial_clock_sel <= regs_q[1][ccrb_pkg::CLK_SCLK_LSB +: 2];
            ctrl_o.master_clock_sel <= regs_q[1][ccrb_pkg::CLK_MCLK_LSB +: 3];
            ctrl_o.control_word_echo_enable   <= regs_q[1][ccrb_pkg::CLK_ECHO_BIT];
            ctrl_o.global_power_on            <= regs_q[2][ccrb_pkg::PWR_GLOBAL_BIT];
            ctrl_o.analog_tap_power_on        <= regs_q[2][ccrb_pkg::PWR_ATAP_BIT];
            ctrl_o.inbound_amplifier_power_on <= regs_q[2][ccrb_pkg::PWR_INAMP_BIT];
            ctrl_o.adc_power_on               <= regs_q[2][ccrb_pkg::PWR_ADC_BIT];
            ctrl_o.dac_power_on               <= regs_q[2][ccrb_pkg::PWR_DAC_BIT];
            ctrl_o.reference_power_on         <= regs_q[2][ccrb_pkg::PWR_REF_BIT];
            ctrl_o.reference_pin_drive        <= regs_q[2][ccrb_pkg::PWR_REFPIN_BIT];
            reference_output_pin_o            <= regs_q[2][ccrb_pkg::PWR_REFPIN_BIT];
            ctrl_o.inbound_gain_sel     <= regs_q[3][ccrb_pkg::GAIN_IN_LSB +: 3];
            ctrl_o.outbound_gain_sel    <= regs_q[3][ccrb_pkg::GAIN_OUT_LSB +: 3];
            ctrl_o.modulator_reset_hold <= regs_q[3][ccrb_pkg::GAIN_MODRST_BIT];
            ctrl_o.converter_mute       <= regs_q[3][ccrb_pkg::GAIN_MUTE_BIT];
            ctrl_o.converter_lead        <= regs_q[4][ccrb_pkg::TIM_LEAD_LSB +: 5];
            ctrl_o.interpolator_skip     <= regs_q[4][ccrb_pkg::TIM_ISKIP_BIT];
            ctrl_o.test_operation_enable <= regs_q[4][ccrb_pkg::TIM_TEST_BIT];
            ctrl_o.digital_tap_enable    <= regs_q[4][ccrb_pkg::TIM_DTAP_BIT];
            ctrl_o.digital_tap_coeff_low <= regs_q[6];
            ctrl_o.analog_tap_coeff      <= regs_q[5][ccrb_pkg::ATAP_COEFF_LSB +: 5];
            ctrl_o.single_ended_or_tap_enable <= regs_q[5][ccrb_pkg::ATAP_SEEN_BIT];
            ctrl_o.analog_loop_or_tap_silence <= regs_q[5][ccrb_pkg::ATAP_LOOP_BIT];
            ctrl_o.polarity_flip_enable       <= regs_q[5][ccrb_pkg::ATAP_INV_BIT];
        end
    end

    // ------------------------------------------------------------
    // Serial clock and sample rate enables
    // ------------------------------------------------------------
    // Counters reload on reset so the slowest rates apply from the start
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_cnt_q <= ccrb_pkg::DIV_8;
            sclk_en_o  <= 1'b0;
        end else if (in_reset) begin
            sclk_cnt_q <= ccrb_pkg::DIV_8;
            sclk_en_o  <= 1'b0;
        end else begin
            sclk_en_o <= mclk_en_i && (sclk_cnt_q == 4'h0);
            if (mclk_en_i) begin
                sclk_cnt_q <= (sclk_cnt_q == 4'h0) ?
                              ccrb_sclk_div(regs_q[1][ccrb_pkg::CLK_SCLK_LSB +: 2]) :
                              sclk_cnt_q - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rate_cnt_q  <= ccrb_pkg::DIV_2048;
            sample_en_o <= 1'b0;
        end else if (in_reset) begin
            rate_cnt_q  <= ccrb_pkg::DIV_2048;
            sample_en_o <= 1'b0;
        end else begin
            sample_en_o <= mclk_en_i && (rate_cnt_q == 12'h000);
            if (mclk_en_i) begin
                rate_cnt_q <= (rate_cnt_q == 12'h000) ?
                              ccrb_rate_div(regs_q[1][ccrb_pkg::CLK_RATE_LSB +: 2]) :
                              rate_cnt_q - 12'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_swrst;
        swrst_req && pin_sync_q;
    endsequence

    AST_SWRST_CLEARS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_swrst |=> (regs_q[0] == 8'h00) && in_reset)
        else $error("software reset did not clear mode register");

    AST_RESET_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        in_reset |-> ##1 (regs_q[1] == 8'h00 && regs_q[2] == 8'h00))
        else $error("registers not zero during reset");

    AST_RESET_MIN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state_q == ccrb_pkg::CCRB_RUN && $past(state_q) == ccrb_pkg::CCRB_HOLD)
        |-> $past(rst_cnt_q) == 3'h3)
        else $error("reset ended before four master ticks");

    AST_WRITE_STORES: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (wr_en_i && reg_addr_i == ccrb_pkg::REG_POWER && !in_reset && pin_sync_q)
        |-> ##2 ctrl_o.global_power_on == $past(wr_data_i[0], 2))
        else $error("power write not seen on control");

    AST_REFPIN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 reference_output_pin_o == $past(regs_q[2][ccrb_pkg::PWR_REFPIN_BIT]))
        else $error("reference pin not following power bit 6");

    AST_MODE_FIELDS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.cascade_count == $past(regs_q[0][6:4]))
        else $error("cascade count decode wrong");

    AST_MUTE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.converter_mute == $past(regs_q[3][7]))
        else $error("mute decode wrong");

    AST_SCLK_DEFAULT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (sclk_en_o && regs_q[1][3:2] == 2'h0 && $past(regs_q[1][3:2], 8) == 2'h0 && !in_reset
         && $past(regs_q[1][3:2]) == 2'h0)
        |=> !sclk_en_o [*2])
        else $error("serial clock enable too fast at divide by 8");

    AST_RATE_FAST: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (rate_cnt_q == 12'h000 && mclk_en_i && !in_reset && regs_q[1][1:0] == 2'h3)
        |=> rate_cnt_q == 12'h0FF)
        else $error("sample divider reload wrong for divide by 256");

    // Mode and clock fields reach the decoded controls one cycle later
    AST_OPMODE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.operating_mode_select == $past(regs_q[0][0]))
        else $error("operating mode decode wrong");

    AST_MIXED: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.mixed_operation_enable == $past(regs_q[0][1]))
        else $error("mixed mode decode wrong");

    AST_LOOPS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 {ctrl_o.serial_port_loopback_enable, ctrl_o.digital_loopback_enable} == $past(regs_q[0][3:2]))
        else $error("loopback decode wrong");

    AST_RATE_SEL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.sample_rate_sel == $past(regs_q[1][1:0]))
        else $error("rate select decode wrong");

    AST_SCLK_SEL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.serial_clock_sel == $past(regs_q[1][3:2]))
        else $error("serial clock select decode wrong");

    AST_MCLK_SEL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.master_clock_sel == $past(regs_q[1][6:4]))
        else $error("master clock select decode wrong");

    AST_ECHO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.control_word_echo_enable == $past(regs_q[1][7]))
        else $error("echo enable decode wrong");

    // Power and gain fields; a slip here only shows in the analog domain
    AST_SECTION_PWR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 {ctrl_o.reference_power_on, ctrl_o.dac_power_on, ctrl_o.adc_power_on,
             ctrl_o.inbound_amplifier_power_on, ctrl_o.analog_tap_power_on} == $past(regs_q[2][5:1]))
        else $error("section power decode wrong");

    AST_GAIN_SEL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 {ctrl_o.outbound_gain_sel, ctrl_o.inbound_gain_sel} == $past({regs_q[3][6:4], regs_q[3][2:0]}))
        else $error("gain select decode wrong");

    AST_MODRST: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.modulator_reset_hold == $past(regs_q[3][3]))
        else $error("modulator reset decode wrong");

    // Timing and tap fields
    AST_LEAD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.converter_lead == $past(regs_q[4][4:0]))
        else $error("load advance decode wrong");

    AST_ISKIP_TEST: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 {ctrl_o.test_operation_enable, ctrl_o.interpolator_skip} == $past({regs_q[4][7], regs_q[4][5]}))
        else $error("skip or test decode wrong");

    AST_DTAP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 {ctrl_o.digital_tap_enable, ctrl_o.digital_tap_coeff_low} == $past({regs_q[4][6], regs_q[6]}))
        else $error("digital tap decode wrong");

    AST_ATAP_COEFF: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.analog_tap_coeff == $past(regs_q[5][4:0]))
        else $error("analog tap coefficient decode wrong");

    AST_ATAP_FLAGS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 {ctrl_o.analog_loop_or_tap_silence, ctrl_o.single_ended_or_tap_enable}
            == $past({regs_q[5][7], regs_q[5][5]}))
        else $error("analog tap flag decode wrong");

    AST_INVERT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 ctrl_o.polarity_flip_enable == $past(regs_q[5][6]))
        else $error("polarity flip decode wrong");

endmodule

// File: ccrb_dsp_port.sv
// Behavioural DSP serial port: issues register writes and reads as strobes.
// Assumes the bank takes strobes on the rising edge of clk_i.
`timescale 1ns/100ps
module ccrb_dsp_port (
    // Clock and read answer
    input  wire logic       clk_i,
    input  wire logic       rd_valid_i,
    input  wire logic [7:0] rd_data_i,
    // Requests to the bank
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic [2:0]      addr_o,
    output logic [7:0]      data_o
);
    // Idle lines at time zero
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 3'h0;
        data_o  = 8'h00;
    end
    // Lines inverted after release so stale values never pass for live ones
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_en_o = 1'b1;
        addr_o  = a;
        data_o  = (a == ccrb_pkg::REG_POWER) ? {1'b0, d[6:0]} : d;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        addr_o  = ~addr_o;
        data_o  = ~data_o;
    endtask
    // Read: answer taken only while the valid pulse stands, bounded wait
    task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_i);
        rd_en_o = 1'b1;
        addr_o  = a;
        @(negedge clk_i);
        rd_en_o = 1'b0;
        addr_o  = ~addr_o;
        ok      = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rd_valid_i === 1'b1) begin
                ok = 1'b1;
                d  = rd_data_i;
            end else @(negedge clk_i);
        end
    endtask
endmodule

// File: ccrb_bank_bench.sv
// Self-checking bench of the codec control register bank.
// Assumes ccrb_pkg and the serial port model are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module ccrb_bank_bench;
    logic                    clk_i = 1'b0, arst_n_i = 1'b0, mclk_en_i = 1'b0, reset_pin_n_i = 1'b1;
    logic                    wr_en, rd_en, rd_valid, refpin, busy, sclk_en, sample_en;
    logic [2:0]              addr;
    logic [7:0]              wdata, rd_data;
    logic [7:0]              regs [7] = '{default: 8'h00};
    ccrb_pkg::ccrb_ctrl_type ctrl;
    int                      mismatches = 0, checks_done = 0, mmode = 0, pulses = 0, p;
    int                      seed = 32'h351f35aa;
    // ----------------------------------------
    // Clock, master clock ticks, instances
    // ----------------------------------------
    initial forever #20 clk_i = ~clk_i;
    // Ticks: random, steady, or counted out by hand for exact reset timing
    always @(negedge clk_i) begin
        mclk_en_i <= (mmode == 0) ? 1'($random(seed)) : 1'((mmode == 1) || (pulses > 0));
        if (mmode == 2 && pulses > 0) pulses <= pulses - 1;
    end
    ccrb_dsp_port port (.clk_i(clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .wr_en_o(wr_en),
        .rd_en_o(rd_en), .addr_o(addr), .data_o(wdata));
    ccrb_bank uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .mclk_en_i(mclk_en_i), .reset_pin_n_i(reset_pin_n_i),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .reg_addr_i(addr), .wr_data_i(wdata), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .ctrl_o(ctrl), .reference_output_pin_o(refpin), .reset_busy_o(busy),
        .sclk_en_o(sclk_en), .sample_en_o(sample_en));
    // Decoded controls expected from the shadow registers
    function automatic logic [53:0] exp_ctrl();
        return {regs[0][0], regs[0][1], regs[0][2], regs[0][3], regs[0][6:4], regs[1][1:0], regs[1][3:2],
            regs[1][6:4], regs[1][7], regs[2][0], regs[2][1], regs[2][2], regs[2][3], regs[2][4], regs[2][5],
            regs[2][6], regs[3][2:0], regs[3][3], regs[3][6:4], regs[3][7], regs[4][4:0], regs[4][5],
            regs[4][6], regs[4][7], regs[5][4:0], regs[5][5], regs[5][6], regs[5][7], regs[6]};
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Read back every index, unmapped one included, then the decoded bundle
    task automatic check_all;
        logic [7:0]  d;
        logic        ok;
        logic [53:0] e;
        for (int a = 0; a < 8; a++) begin
            port.rd(a[2:0], d, ok);
            `CHK(ok, 1'b1)
            `CHK(d, (a < 7) ? regs[a] : 8'h00)
        end
        e = exp_ctrl();
        `CHK(ctrl[53:32], e[53:32])
        `CHK(ctrl[31:0], e[31:0])
        `CHK(refpin, regs[2][6])
    endtask
    // Mode register last, so data mode only begins once the rest is loaded
    task automatic fill_ones;
        for (int a = 6; a >= 0; a--) begin
            regs[a] = (a == 0 || a == 2) ? 8'h7F : 8'hFF;
            port.wr(a[2:0], regs[a]);
        end
        check_all();
    endtask
    // Ticks held off: busy must stay through 3 ticks and end after the 4th
    task automatic reset_walk;
        port.wr(ccrb_pkg::REG_GAIN, 8'hFF);
        repeat (6) @(negedge clk_i);
        `CHK(busy, 1'b1)
        @(posedge clk_i) pulses = 3;
        repeat (12) @(negedge clk_i);
        `CHK(busy, 1'b1)
        @(posedge clk_i) pulses = 1;
        repeat (4) @(negedge clk_i);
        `CHK(busy, 1'b0)
        regs = '{default: 8'h00};
        check_all();
    endtask
    initial begin
        logic [2:0] a;
        logic [7:0] d;
        repeat (16) @(negedge clk_i);
        arst_n_i = 1'b1;
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_i);
        if (busy !== 1'b0) begin
            mismatches++;
            print_verdict();
        end
        check_all();
        // Random traffic; mode writes keep bit 7 clear so no software reset wipes the bank, and stay in program mode
        repeat (30) begin
            a = 3'($unsigned($random(seed)) % 7);
            d = 8'($random(seed));
            if (a == 3'h0) d[7:0] = {1'b0, d[6:1], 1'b0};
            regs[a] = (a == 3'h2) ? {1'b0, d[6:0]} : d;
            port.wr(a, d);
        end
        check_all();
        fill_ones();
        @(posedge clk_i) mmode = 2;
        port.wr(ccrb_pkg::REG_MODE, 8'hFF);
        reset_walk();
        fill_ones();
        @(posedge clk_i) mmode = 2;
        @(negedge clk_i) reset_pin_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        reset_pin_n_i = 1'b1;
        reset_walk();
        // Dividers with a tick every cycle; first period may use the old code
        @(posedge clk_i) mmode = 1;
        for (int c = 0; c < 4; c++) begin
            port.wr(ccrb_pkg::REG_CLOCK, {4'h0, 2'(c), 2'(c)});
            for (int s = 0; s < 2; s++) begin
                int k, t2;
                k  = 0;
                t2 = 0;
                p  = -1;
                for (int n = 0; n < 9000 && k < 3; n++) begin
                    @(negedge clk_i);
                    if ((s ? sample_en : sclk_en) === 1'b1) begin
                        k++;
                        if (k == 2) t2 = n;
                        if (k == 3) p = n - t2;
                    end
                end
                `CHK(p, s ? (2048 >> c) : (8 >> c))
            end
        end
        print_verdict();
    end
endmodule
